// >>> verilog/port_c_mux_pkg.sv
// constants for the port c pin mux and read port block
// assumes one byte-wide register per aligned axi4-lite word
package port_c_mux_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [3:0] OFS_LOW_FUNC  = 4'h0;
  localparam logic [3:0] OFS_HIGH_FUNC = 4'h4;
  localparam logic [3:0] OFS_ROUTING   = 4'h8;
  localparam logic [3:0] OFS_UNLOCK    = 4'hc;

  // ****************************************************************
  // reset values and fixed patterns
  // ****************************************************************
  localparam logic [7:0] RST_REG        = 8'h00;
  localparam logic [7:0] UNLOCK_PATTERN = 8'hca;
  localparam logic [7:0] FUNC_MASK      = 8'h77;
  localparam logic [7:0] ROUTE_MASK     = 8'h7f;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int HI_FIELD_LSB = 4;
  localparam int LO_FIELD_LSB = 0;
  localparam int TMR_SEL_BIT  = 4;
  localparam int SDA_SEL_LSB  = 2;
  localparam int SCL_SEL_LSB  = 0;

  // ****************************************************************
  // axi responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : port_c_mux_pkg

// >>> verilog/port_c_pin_mux.sv
// port c pin function mux, input source routing and read port mode
// assumes pins are synchronised here; peripherals share clk
`timescale 1ns/1ns

module port_c_pin_mux (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port c pins (bits 3:0), and pins feeding routing
  input  wire logic [3:0]  port_c_pin_in,
  output logic [3:0]       port_c_pin_out,
  output logic [3:0]       port_c_pin_oe_n,
  input  wire logic        port_a_bit0,
  input  wire logic        port_a_bit2,
  input  wire logic        port_b_bit0,
  input  wire logic        port_b_bit1,
  input  wire logic        port_b_bit4,
  // port c data latch and direction (1 = input)
  input  wire logic [3:0]  port_c_latch,
  input  wire logic [3:0]  port_c_dir_in,
  // peripheral signals driven out on pins
  input  wire logic        comparator0_debounced_out,
  input  wire logic        comparator1_debounced_out,
  input  wire logic        comparator2_debounced_out,
  input  wire logic        comparator3_debounced_out,
  input  wire logic        comparator4_debounced_out,
  input  wire logic        comparator4_raw_out,
  input  wire logic        peripheral_clock_out,
  input  wire logic        i2c_scl_out,
  input  wire logic        i2c_sda_out,
  // peripheral inputs taken from pins
  output logic             timer1_ext_clock,
  output logic             i2c_sda_in,
  output logic             i2c_scl_in,
  output logic             low_voltage_detect_sel,
  output logic             comparator3_neg_input_en,
  output logic             comparator5_neg_input_en,
  // analog switch enables for analog inputs 10, 11, 13
  output logic             analog_input_10_en,
  output logic             analog_input_11_en,
  output logic             analog_input_13_en,
  // port c read path to the accumulator
  output logic [3:0]       port_c_read_data,
  output logic             read_port_mode
);
  import port_c_mux_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  low_func_ff;
  logic [7:0]  high_func_ff;
  logic [7:0]  routing_ff;
  logic [7:0]  unlock_ff;
  logic [3:0]  pin_meta_ff;
  logic [3:0]  pin_sync_ff;
  logic [4:0]  oth_meta_ff;
  logic [4:0]  oth_sync_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [3:0]  aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;

  // ****************************************************************
  // select fields and decoded pin functions
  // ****************************************************************
  logic [2:0]  c0_sel;
  logic [2:0]  c1_sel;
  logic [2:0]  c2_sel;
  logic [2:0]  c3_sel;
  logic        wr_fire;
  logic [3:0]  pin_drive;
  logic [3:0]  pin_is_io;
  logic [3:0]  pin_is_i2c;
  logic [3:0]  pin_is_ana;

  assign c0_sel = low_func_ff[LO_FIELD_LSB +: 3];
  assign c1_sel = low_func_ff[HI_FIELD_LSB +: 3];
  assign c2_sel = high_func_ff[LO_FIELD_LSB +: 3];
  assign c3_sel = high_func_ff[HI_FIELD_LSB +: 3];

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= 4'h0;
      pin_sync_ff <= 4'h0;
      oth_meta_ff <= 5'h00;
      oth_sync_ff <= 5'h00;
    end else if (ce) begin
      pin_meta_ff <= port_c_pin_in;
      pin_sync_ff <= pin_meta_ff;
      oth_meta_ff <= {port_b_bit4, port_b_bit1, port_b_bit0,
                      port_a_bit2, port_a_bit0};
      oth_sync_ff <= oth_meta_ff;
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  // ready stays low while frozen, so no beat is taken and then lost
  assign s_axi_awready = ce & ~aw_got_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~w_got_ff & ~s_axi_bvalid;
  assign wr_fire       = aw_got_ff & w_got_ff & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 4'h0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_ff[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // only byte lane 0 carries register data; function bits 3 and 7 and routing bit 7 are not stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_func_ff  <= RST_REG;
      high_func_ff <= RST_REG;
      routing_ff   <= RST_REG;
      unlock_ff    <= RST_REG;
    end else if (ce && wr_fire && w_strb_ff[0]) begin
      unique case (aw_addr_ff)
        OFS_LOW_FUNC:  low_func_ff  <= w_data_ff[7:0] & FUNC_MASK;
        OFS_HIGH_FUNC: high_func_ff <= w_data_ff[7:0] & FUNC_MASK;
        OFS_ROUTING:   routing_ff   <= w_data_ff[7:0] & ROUTE_MASK;
        OFS_UNLOCK:    unlock_ff    <= w_data_ff[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign s_axi_arready = ce & ~s_axi_rvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_LOW_FUNC:  s_axi_rdata <= {24'h000000, low_func_ff};
          OFS_HIGH_FUNC: s_axi_rdata <= {24'h000000, high_func_ff};
          OFS_ROUTING:   s_axi_rdata <= {24'h000000, routing_ff};
          OFS_UNLOCK:    s_axi_rdata <= {24'h000000, unlock_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // read port mode
  // ****************************************************************
  assign read_port_mode = (unlock_ff == UNLOCK_PATTERN);

  // ****************************************************************
  // pin function decode
  // ****************************************************************
  always_comb begin
    pin_drive  = 4'h0;
    pin_is_io  = 4'h0;
    pin_is_i2c = 4'h0;
    pin_is_ana = 4'h0;
    comparator3_neg_input_en = 1'b0;
    comparator5_neg_input_en = 1'b0;
    low_voltage_detect_sel   = 1'b0;
    unique case (c0_sel)
      3'h0, 3'h7: pin_is_io[0] = 1'b1;
      3'h1: pin_drive[0] = 1'b1;
      3'h2: comparator3_neg_input_en = 1'b1;
      3'h3: pin_is_ana[0] = 1'b1;
      3'h4: begin
        comparator3_neg_input_en = 1'b1;
        pin_is_ana[0] = 1'b1;
      end
      default: ;
    endcase
    unique case (c1_sel)
      3'h0: pin_is_io[1] = 1'b1;
      3'h1, 3'h2: pin_drive[1] = 1'b1;
      3'h3: comparator3_neg_input_en = 1'b1;
      3'h4: pin_is_i2c[1] = 1'b1;
      3'h7: pin_is_ana[1] = 1'b1;
      default: ;
    endcase
    unique case (c2_sel)
      3'h0, 3'h7: pin_is_io[2] = 1'b1;
      3'h1: low_voltage_detect_sel = 1'b1;
      3'h2, 3'h3: pin_drive[2] = 1'b1;
      3'h4: pin_is_i2c[2] = 1'b1;
      3'h6: comparator5_neg_input_en = 1'b1;
      default: ;
    endcase
    unique case (c3_sel)
      3'h0, 3'h5, 3'h6, 3'h7: pin_is_io[3] = 1'b1;
      3'h1: pin_is_ana[3] = 1'b1;
      3'h2, 3'h3: pin_drive[3] = 1'b1;
      default: ;
    endcase
  end

  // ****************************************************************
  // pin drivers (i2c lines are open drain)
  // ****************************************************************
  always_comb begin
    port_c_pin_out[0] = c0_sel == 3'h1 ? comparator0_debounced_out
                                       : port_c_latch[0];
    port_c_pin_out[1] = c1_sel == 3'h1 ? comparator1_debounced_out
                      : c1_sel == 3'h2 ? peripheral_clock_out
                      : c1_sel == 3'h4 ? 1'b0 : port_c_latch[1];
    port_c_pin_out[2] = c2_sel == 3'h2 ? comparator4_raw_out
                      : c2_sel == 3'h3 ? comparator2_debounced_out
                      : c2_sel == 3'h4 ? 1'b0 : port_c_latch[2];
    port_c_pin_out[3] = c3_sel == 3'h2 ? comparator3_debounced_out
                      : c3_sel == 3'h3 ? comparator4_debounced_out
                                       : port_c_latch[3];
    port_c_pin_oe_n = ~(pin_drive | (pin_is_io & ~port_c_dir_in));
    if (pin_is_i2c[1] && !i2c_scl_out) port_c_pin_oe_n[1] = 1'b0;
    if (pin_is_i2c[2] && !i2c_sda_out) port_c_pin_oe_n[2] = 1'b0;
  end

  // ****************************************************************
  // input source routing
  // ****************************************************************
  always_comb begin
    timer1_ext_clock = routing_ff[TMR_SEL_BIT] ? pin_sync_ff[3]
                                               : oth_sync_ff[3];
    unique case (routing_ff[SDA_SEL_LSB +: 2])
      2'h0: i2c_sda_in = oth_sync_ff[0];
      2'h1: i2c_sda_in = oth_sync_ff[3];
      2'h2: i2c_sda_in = oth_sync_ff[2];
      2'h3: i2c_sda_in = pin_sync_ff[2];
    endcase
    unique case (routing_ff[SCL_SEL_LSB +: 2])
      2'h0: i2c_scl_in = oth_sync_ff[1];
      2'h1: i2c_scl_in = oth_sync_ff[0];
      2'h2: i2c_scl_in = oth_sync_ff[4];
      2'h3: i2c_scl_in = pin_sync_ff[1];
    endcase
  end

  // ****************************************************************
  // analog path and read path
  // ****************************************************************
  assign analog_input_10_en = pin_is_ana[0] | read_port_mode;
  assign analog_input_11_en = pin_is_ana[3] | read_port_mode;
  assign analog_input_13_en = pin_is_ana[1] | read_port_mode;

  // normal read: pins for inputs and i2c, latch for outputs, 0 for analog
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_read
      assign port_c_read_data[gi] =
        read_port_mode ? pin_sync_ff[gi]
        : pin_is_ana[gi] ? 1'b0
        : (pin_is_i2c[gi] || (port_c_dir_in[gi] && !pin_drive[gi]))
          ? pin_sync_ff[gi] : port_c_latch[gi];
    end
  endgenerate

endmodule : port_c_pin_mux

// >>> test/port_c_pin_mux_asserts.sv
// port-level checks for the port c pin mux and read port block
// assumes rstn active low and all checks on clk
`timescale 1ns/1ns
module port_c_pin_mux_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins and mode
  input wire logic [3:0]  port_c_pin_in,
  input wire logic [3:0]  port_c_read_data,
  input wire logic        read_port_mode,
  input wire logic        low_voltage_detect_sel,
  input wire logic        comparator5_neg_input_en,
  input wire logic        analog_input_10_en,
  input wire logic        analog_input_11_en,
  input wire logic        analog_input_13_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // register bus
  // ****************************************************************
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or wide");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer not held");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  rd_clear_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not cleared");
  wr_busy_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready ##1 !(s_axi_bvalid && $past(s_axi_bready)))
    else $error("write taken while answer pending");

  // ****************************************************************
  // read port mode
  // ****************************************************************
  analog_forced_a: assert property (read_port_mode |->
    analog_input_10_en && analog_input_11_en && analog_input_13_en)
    else $error("analog path not forced on");
  pin_read_a: assert property (read_port_mode && $past(ce) &&
    $past(ce, 2) |-> port_c_read_data == $past(port_c_pin_in, 2))
    else $error("read data not pin level");
  mode_only_read_a: assert property ($changed(read_port_mode) |->
    $stable(low_voltage_detect_sel) && $stable(comparator5_neg_input_en))
    else $error("mode change moved a pin function");
endmodule : port_c_pin_mux_asserts

bind port_c_pin_mux port_c_pin_mux_asserts chk (.*);

// >>> test/tb_port_c_pin_mux.sv
// bench for the port c pin mux: registers, pin functions, routing, read port
// assumes the checker binds itself from its own file
`timescale 1ns/1ns
module tb_port_c_pin_mux;
  import port_c_mux_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk = 0;
  logic        rstn = 0;
  logic        ce;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  port_c_pin_in, port_c_latch, port_c_dir_in;
  logic [3:0]  port_c_pin_out, port_c_pin_oe_n, port_c_read_data;
  logic        port_a_bit0, port_a_bit2, port_b_bit0, port_b_bit1;
  logic        port_b_bit4, comparator0_debounced_out;
  logic        comparator1_debounced_out, comparator2_debounced_out;
  logic        comparator3_debounced_out, comparator4_debounced_out;
  logic        comparator4_raw_out, peripheral_clock_out;
  logic        i2c_scl_out, i2c_sda_out, timer1_ext_clock, i2c_sda_in;
  logic        i2c_scl_in, low_voltage_detect_sel, read_port_mode;
  logic        comparator3_neg_input_en, comparator5_neg_input_en;
  logic        analog_input_10_en, analog_input_11_en, analog_input_13_en;
  logic [33:0] rq[$], bq[$];
  logic [31:0] seed = 32'h212c5a79;
  int          bad_count = 0;
  int          n_checks = 0;

  port_c_pin_mux uut (.*);

  always #4 clk = ~clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [33:0] s, input logic [33:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic tmo(input int n);
    if (n < 40) return;
    bad_count++;
    stop_test();
  endtask : tmo

  // pins and peripheral sources all move at once
  task automatic drive(input logic [31:0] v);
    {port_c_pin_in, port_c_latch, port_c_dir_in, port_a_bit0, port_a_bit2,
     port_b_bit0, port_b_bit1, port_b_bit4, comparator0_debounced_out,
     comparator1_debounced_out, comparator2_debounced_out,
     comparator3_debounced_out, comparator4_debounced_out,
     comparator4_raw_out, peripheral_clock_out, i2c_scl_out,
     i2c_sda_out} <= v[25:0];
  endtask : drive

  // ready raised after a random stall, held until the answer
  task automatic reply(input bit r);
    int n;
    repeat (xs() % 3) @(posedge clk);
    s_axi_rready <= r;
    s_axi_bready <= !r;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (r ? s_axi_rvalid : s_axi_bvalid) break;
    end
    s_axi_rready <= 0;
    s_axi_bready <= 0;
    tmo(n);
  endtask : reply

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        aw;
    logic        w;
    int          n;
    r = xs();
    aw = 0;
    w = 0;
    bq.push_back({a[1:0] != 2'h0 ? RESP_SLVERR : RESP_OKAY, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {r[23:0], d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (n = 0; n < 40 && !(aw && w); n++) begin
      @(posedge clk);
      aw |= s_axi_awvalid & s_axi_awready;
      w |= s_axi_wvalid & s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    tmo(n);
    reply(0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    int n;
    rq.push_back({a[1:0] != 2'h0 ? RESP_SLVERR : RESP_OKAY, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_axi_arready) break;
    end
    s_axi_arvalid <= 0;
    tmo(n);
    reply(1);
  endtask : rd

  task automatic pin(input int i, input bit f, input logic v, input bit g);
    if (f || g) check(port_c_pin_oe_n[i], f ? 1'b0 : port_c_dir_in[i]);
    if (f || g && !port_c_dir_in[i])
      check(port_c_pin_out[i], f ? v : port_c_latch[i]);
  endtask : pin

  // ****************************************************************
  // answer monitor
  // ****************************************************************
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready)
      check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      check({s_axi_bresp, 32'h0}, bq.pop_front());
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [3:0] ofs[4];
    logic [3:0] sel;
    ofs = '{OFS_LOW_FUNC, OFS_HIGH_FUNC, OFS_ROUTING, OFS_UNLOCK};
    drive(0);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid,
     s_axi_bready, s_axi_arvalid, s_axi_rready} <= 0;
    ce <= 1;
    s_axi_wstrb <= 4'hf;
    repeat (8) @(posedge clk);
    rstn <= 1;
    check(read_port_mode, 0);
    for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], i == 2 ? 8'h9f : 8'hff);
      rd(ofs[i], i == 2 ? 8'h1f : 8'h77);
    end
    // misaligned address and empty byte lane must leave registers alone
    wr(4'h1, 8'h00);
    s_axi_wstrb <= 4'he;
    wr(OFS_LOW_FUNC, 8'h00);
    s_axi_wstrb <= 4'hf;
    rd(4'h2, 8'h00);
    rd(OFS_LOW_FUNC, 8'h77);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_UNLOCK, m ? 8'hca : 8'h4a);
      rd(OFS_UNLOCK, m ? 8'hca : 8'h4a);
      for (int k = 0; k < 8; k++) begin
        wr(OFS_LOW_FUNC, {1'b0, k[2:0], 1'b0, k[2:0]});
        wr(OFS_HIGH_FUNC, {1'b0, k[2:0], 1'b0, k[2:0]});
        drive(xs());
        repeat (3) @(posedge clk);
        pin(0, k == 1, comparator0_debounced_out, k == 0 || k == 7);
        pin(1, k == 1 || k == 2, k == 1 ? comparator1_debounced_out :
          peripheral_clock_out, k == 0);
        pin(2, k == 2 || k == 3, k == 2 ? comparator4_raw_out :
          comparator2_debounced_out, k == 0 || k == 7);
        pin(3, k == 2 || k == 3, k == 2 ? comparator3_debounced_out :
          comparator4_debounced_out, k == 0 || k > 4);
        check(analog_input_10_en, m || k == 3 || k == 4);
        check(analog_input_11_en, m || k == 1);
        check(analog_input_13_en, m || k == 7);
        check(comparator3_neg_input_en, k inside {2, 3, 4});
        check(low_voltage_detect_sel, k == 1);
        check(comparator5_neg_input_en, k == 6);
        if (k == 4) check({port_c_pin_oe_n[2:1], port_c_pin_out[2:1]},
          {i2c_sda_out, i2c_scl_out, 2'h0});
        if (!m && k == 4) check(port_c_read_data,
          {port_c_dir_in[3] ? port_c_pin_in[3] : port_c_latch[3],
           port_c_pin_in[2:1], 1'b0});
        check(read_port_mode, m);
        if (m || k == 0) check(port_c_read_data, m ? port_c_pin_in :
          port_c_dir_in & port_c_pin_in | ~port_c_dir_in & port_c_latch);
      end
    end
    for (int r = 0; r < 16; r++) begin
      wr(OFS_ROUTING, {3'h0, r[0], r[3:0]});
      drive(xs());
      repeat (3) @(posedge clk);
      sel = {port_c_pin_in[2], port_b_bit0, port_b_bit1, port_a_bit0};
      check(i2c_sda_in, sel[r[3:2]]);
      sel = {port_c_pin_in[1], port_b_bit4, port_a_bit0, port_a_bit2};
      check(i2c_scl_in, sel[r[1:0]]);
      check(timer1_ext_clock, r[0] ? port_c_pin_in[3] : port_b_bit1);
    end
    // frozen block keeps the old routed levels, then catches up
    ce <= 0;
    port_c_pin_in <= ~port_c_pin_in;
    repeat (3) @(posedge clk);
    check({timer1_ext_clock, i2c_sda_in, i2c_scl_in} ^ port_c_pin_in[3:1],
      3'h7);
    ce <= 1;
    repeat (3) @(posedge clk);
    check({timer1_ext_clock, i2c_sda_in, i2c_scl_in}, port_c_pin_in[3:1]);
    stop_test();
  end
endmodule : tb_port_c_pin_mux
